/* File: tpr_pkg.sv */
package tpr_pkg;

  localparam int REG_W = 16;
  localparam int PIX_W = 3 * REG_W;
  localparam int BEAT_W = PIX_W + 2;
  localparam int FIFO_DEPTH = 16;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [2:0] IDX_RUN_CONTROL = 3'h0;
  localparam logic [2:0] IDX_RUN_STATUS = 3'h1;
  localparam logic [2:0] IDX_FRAME_WIDTH = 3'h2;
  localparam logic [2:0] IDX_FRAME_HEIGHT = 3'h3;
  localparam logic [2:0] IDX_COLOUR_FIRST = 3'h4;
  localparam logic [2:0] IDX_COLOUR_SECOND = 3'h5;
  localparam logic [2:0] IDX_COLOUR_THIRD = 3'h6;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 4;

  localparam int RUN_BIT = 0;
  localparam int STATUS_BIT = 0;

  localparam logic [15:0] RST_RUN_CONTROL = 16'h0000;
  localparam logic [15:0] RST_FRAME_WIDTH = 16'h0020;
  localparam logic [15:0] RST_FRAME_HEIGHT = 16'h0020;
  localparam logic [15:0] RST_COLOUR = 16'h0000;

  // Packet type codes carried in the low nibble of a header beat.
  localparam logic [3:0] PKT_IMAGE = 4'h0;
  localparam logic [3:0] PKT_CONTROL = 4'hF;
  // Frame-format nibble of the control packet body.
  localparam logic [3:0] FMT_PROGRESSIVE = 4'h2;
  localparam logic [3:0] FMT_FIELD_FIRST = 4'h8;
  localparam logic [3:0] FMT_FIELD_SECOND = 4'hC;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_CTRL_HDR  = 3'b001,
    ST_CTRL_BODY = 3'b010,
    ST_IMG_HDR   = 3'b011,
    ST_PIXELS    = 3'b100
  } tpr_state_t;

endpackage

/* File: tpr_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tpr_stream_if #(parameter int W = 50) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* File: tpr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tpr_fifo #(
  parameter int W     = 50,
  parameter int DEPTH = 16
) (
  input wire logic    pclk,
  input wire logic    presetn,
  input wire logic    ce,
  tpr_stream_if.snk   wr,
  tpr_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [W-1:0]  q;
  logic          qv;

  wire push = wr.valid && wr.ready;
  wire load = (cnt != '0) && (!qv || rd.ready);

  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign rd.data  = q;
  assign rd.valid = qv;

  always_ff @(posedge pclk) begin
    if (ce && push) begin
      mem[wp] <= wr.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
      q   <= '0;
      qv  <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wp <= AW'(wp + 1'b1);
      end
      if (load) begin
        rp <= AW'(rp + 1'b1);
        q  <= mem[rp];
        qv <= 1'b1;
      end else if (rd.ready) begin
        qv <= 1'b0;
      end
      cnt <= (AW+1)'(cnt + (AW+1)'(push) - (AW+1)'(load));
    end
  end
endmodule
`default_nettype wire

/* File: tpr_run_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tpr_run_control #(
  parameter bit UNIFORM_BG = 1'b1,
  parameter bit INTERLACED = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [47:0] dout_data,
  output logic             dout_sop,
  output logic             dout_eop,
  output logic             dout_valid,
  input  wire logic        dout_ready
);
  logic [15:0] run_control;
  logic [15:0] frame_width;
  logic [15:0] frame_height;
  logic [15:0] colour_sample_first;
  logic [15:0] colour_sample_second;
  logic [15:0] colour_sample_third;
  logic        busy;

  logic [15:0] shadow_width;
  logic [15:0] shadow_height;
  logic [47:0] shadow_colour;
  logic        field;
  logic [15:0] xcnt;
  logic [15:0] ycnt;
  logic [31:0] field_pix;

  tpr_pkg::tpr_state_t state;
  tpr_pkg::tpr_state_t next_state;
  localparam int PIXEOP = tpr_pkg::BEAT_W - 2;

  tpr_stream_if #(.W(tpr_pkg::BEAT_W)) gen_if ();
  tpr_stream_if #(.W(tpr_pkg::BEAT_W)) out_if ();

  // Bus decode.
  wire [2:0] idx        = paddr[tpr_pkg::ADDR_IDX_MSB:tpr_pkg::ADDR_IDX_LSB];
  wire       high_zero  = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  wire       is_colour  = (idx == tpr_pkg::IDX_COLOUR_FIRST) || (idx == tpr_pkg::IDX_COLOUR_SECOND) ||
                          (idx == tpr_pkg::IDX_COLOUR_THIRD);
  wire       mapped     = high_zero && (idx != 3'h7) && (!is_colour || UNIFORM_BG);
  wire       acc        = psel && penable;
  wire       wr_ok      = ce && acc && pwrite && mapped;
  wire       setup_rd   = ce && psel && !penable && !pwrite;

  // Zero wait states; an unmapped offset answers with an error and is neither written nor read.
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (mapped) begin
      case (idx)
        tpr_pkg::IDX_RUN_CONTROL:   rd_word = {15'h0000, run_control[tpr_pkg::RUN_BIT]};
        tpr_pkg::IDX_RUN_STATUS:    rd_word = {15'h0000, busy};
        tpr_pkg::IDX_FRAME_WIDTH:   rd_word = frame_width;
        tpr_pkg::IDX_FRAME_HEIGHT:  rd_word = frame_height;
        tpr_pkg::IDX_COLOUR_FIRST:  rd_word = colour_sample_first;
        tpr_pkg::IDX_COLOUR_SECOND: rd_word = colour_sample_second;
        tpr_pkg::IDX_COLOUR_THIRD:  rd_word = colour_sample_third;
        default:                    rd_word = 16'h0000;
      endcase
    end
  end

  // Read data is captured in the setup cycle and held through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      prdata <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_control          <= tpr_pkg::RST_RUN_CONTROL;
      frame_width          <= tpr_pkg::RST_FRAME_WIDTH;
      frame_height         <= tpr_pkg::RST_FRAME_HEIGHT;
      colour_sample_first  <= tpr_pkg::RST_COLOUR;
      colour_sample_second <= tpr_pkg::RST_COLOUR;
      colour_sample_third  <= tpr_pkg::RST_COLOUR;
    end else if (wr_ok) begin
      case (idx)
        tpr_pkg::IDX_RUN_CONTROL:   run_control <= {15'h0000, pwdata[tpr_pkg::RUN_BIT]};
        tpr_pkg::IDX_FRAME_WIDTH:   frame_width <= pwdata[15:0];
        tpr_pkg::IDX_FRAME_HEIGHT:  frame_height <= pwdata[15:0];
        tpr_pkg::IDX_COLOUR_FIRST:  colour_sample_first <= pwdata[15:0];
        tpr_pkg::IDX_COLOUR_SECOND: colour_sample_second <= pwdata[15:0];
        tpr_pkg::IDX_COLOUR_THIRD:  colour_sample_third <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Frame sequencing.
  wire        run_bit    = run_control[tpr_pkg::RUN_BIT];
  wire        fire       = gen_if.valid && gen_if.ready;
  wire [15:0] half_up    = 16'((17'(shadow_height) + 17'h00001) >> 1);
  wire [15:0] half_down  = shadow_height >> 1;
  wire [15:0] field_rows = !INTERLACED ? shadow_height : (field ? half_down : half_up);
  wire        last_col   = (xcnt == 16'(shadow_width - 16'h0001));
  wire        last_row   = (ycnt == 16'(field_rows - 16'h0001));
  wire        last_pix   = last_col && last_row;
  wire        more_field = INTERLACED && !field;
  wire        start      = (state == tpr_pkg::ST_IDLE) && run_bit;
  wire [3:0]  fmt        = !INTERLACED ? tpr_pkg::FMT_PROGRESSIVE :
                           (field ? tpr_pkg::FMT_FIELD_SECOND : tpr_pkg::FMT_FIELD_FIRST);

  always_comb begin
    next_state = state;
    case (state)
      tpr_pkg::ST_IDLE: begin
        if (run_bit) begin
          next_state = tpr_pkg::ST_CTRL_HDR;
        end
      end
      tpr_pkg::ST_CTRL_HDR: begin
        if (fire) begin
          next_state = tpr_pkg::ST_CTRL_BODY;
        end
      end
      tpr_pkg::ST_CTRL_BODY: begin
        if (fire) begin
          next_state = tpr_pkg::ST_IMG_HDR;
        end
      end
      tpr_pkg::ST_IMG_HDR: begin
        if (fire) begin
          next_state = tpr_pkg::ST_PIXELS;
        end
      end
      tpr_pkg::ST_PIXELS: begin
        if (fire && last_pix) begin
          next_state = more_field ? tpr_pkg::ST_CTRL_HDR : tpr_pkg::ST_IDLE;
        end
      end
      default: next_state = tpr_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    gen_if.valid = (state != tpr_pkg::ST_IDLE);
    case (state)
      tpr_pkg::ST_CTRL_HDR:  gen_if.data = {1'b1, 1'b0, 44'h0, tpr_pkg::PKT_CONTROL};
      tpr_pkg::ST_CTRL_BODY: gen_if.data = {1'b0, 1'b1, 12'h000, fmt, field_rows, shadow_width};
      tpr_pkg::ST_IMG_HDR:   gen_if.data = {1'b1, 1'b0, 44'h0, tpr_pkg::PKT_IMAGE};
      tpr_pkg::ST_PIXELS:    gen_if.data = {1'b0, last_pix, shadow_colour};
      default:               gen_if.data = '0;
    endcase
  end

  // Status follows the next state, so it drops for the single idle cycle between frames.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tpr_pkg::ST_IDLE;
      busy  <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      busy  <= (next_state != tpr_pkg::ST_IDLE);
    end
  end

  // The shadow is loaded only when leaving idle, so field two reuses field one's settings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_width  <= tpr_pkg::RST_FRAME_WIDTH;
      shadow_height <= tpr_pkg::RST_FRAME_HEIGHT;
      shadow_colour <= '0;
    end else if (ce && start) begin
      shadow_width  <= frame_width;
      shadow_height <= frame_height;
      shadow_colour <= UNIFORM_BG ? {colour_sample_third, colour_sample_second, colour_sample_first} : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field <= 1'b0;
      xcnt  <= 16'h0000;
      ycnt  <= 16'h0000;
    end else if (ce) begin
      if (start) begin
        field <= 1'b0;
      end else if (state == tpr_pkg::ST_PIXELS && fire && last_pix) begin
        field <= more_field;
      end
      if (state == tpr_pkg::ST_IMG_HDR) begin
        xcnt <= 16'h0000;
        ycnt <= 16'h0000;
      end else if (state == tpr_pkg::ST_PIXELS && fire) begin
        xcnt <= last_col ? 16'h0000 : 16'(xcnt + 16'h0001);
        ycnt <= last_col ? 16'(ycnt + 16'h0001) : ycnt;
      end
    end
  end

  // Pixels of the current field, counted apart from the column and row counters for the checks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_pix <= 32'h00000000;
    end else if (ce) begin
      if (state == tpr_pkg::ST_IMG_HDR) begin
        field_pix <= 32'h00000000;
      end else if (state == tpr_pkg::ST_PIXELS && fire) begin
        field_pix <= 32'(field_pix + 32'h00000001);
      end
    end
  end

  // The FIFO decouples the generator from downstream back-pressure.
  tpr_fifo #(.W(tpr_pkg::BEAT_W), .DEPTH(tpr_pkg::FIFO_DEPTH)) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wr      (gen_if),
    .rd      (out_if)
  );

  assign out_if.ready = dout_ready;
  assign dout_valid   = out_if.valid;
  assign dout_sop     = out_if.data[tpr_pkg::BEAT_W-1];
  assign dout_eop     = out_if.data[tpr_pkg::BEAT_W-2];
  assign dout_data    = out_if.data[tpr_pkg::PIX_W-1:0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_frame_start;
    ce && start;
  endsequence

  sequence s_mid_frame;
    ce && state != tpr_pkg::ST_IDLE && $past(state) != tpr_pkg::ST_IDLE;
  endsequence

  property p_start_sends_ctrl;
    s_frame_start |=> state == tpr_pkg::ST_CTRL_HDR && gen_if.valid && gen_if.data[3:0] == tpr_pkg::PKT_CONTROL;
  endproperty

  chk_reg_width_read: assert property (setup_rd |=> prdata[31:16] == 16'h0000)
    else $error("upper register half not zero");
  chk_shadow_hold_frame: assert property (s_mid_frame |-> $stable(shadow_width) && $stable(shadow_colour))
    else $error("shadow changed during frame");
  chk_ce_freeze_state: assert property (!ce |=> $stable(state) && $stable(run_control) && $stable(prdata))
    else $error("state moved with clock enable low");
  chk_ctrl_first_send: assert property (p_start_sends_ctrl)
    else $error("frame did not open with control packet");
  chk_beat_hold_stall: assert property (dout_valid && !dout_ready |=> dout_valid && $stable(dout_data))
    else $error("beat lost under back-pressure");
  chk_field_ctrl_again: assert property (ce && state == tpr_pkg::ST_PIXELS && fire && last_pix && more_field
    |=> state == tpr_pkg::ST_CTRL_HDR && $stable(shadow_height))
    else $error("second field lacks control packet");
  chk_halt_when_clear: assert property (ce && state == tpr_pkg::ST_IDLE && !run_bit
    |=> state == tpr_pkg::ST_IDLE && $stable(shadow_width))
    else $error("started with run bit clear");
  chk_status_idle_zero: assert property (setup_rd && mapped && idx == tpr_pkg::IDX_RUN_STATUS
    |=> prdata[tpr_pkg::STATUS_BIT] == $past(busy))
    else $error("status read mismatch");
  chk_status_gap_low: assert property (ce && state == tpr_pkg::ST_IDLE && !run_bit |=> !busy)
    else $error("status high while stopped");
  chk_width_line_end: assert property (ce && state == tpr_pkg::ST_PIXELS
    |-> xcnt < shadow_width && ycnt < field_rows)
    else $error("line length wrong");
  chk_height_last_row: assert property (ce && state == tpr_pkg::ST_PIXELS && fire && gen_if.data[PIXEOP]
    |-> 32'(field_pix + 32'h00000001) == 32'(shadow_width) * 32'(field_rows))
    else $error("field height wrong");
  chk_colour_pixel_value: assert property (ce && state == tpr_pkg::ST_PIXELS && gen_if.valid
    |-> gen_if.data[tpr_pkg::PIX_W-1:0] == shadow_colour)
    else $error("pixel colour wrong");
  chk_colour_absent_err: assert property (acc && is_colour && high_zero && !UNIFORM_BG |-> pslverr)
    else $error("absent colour register answered");
  chk_run_busy_until: assert property (s_frame_start |=> busy [*2])
    else $error("status not raised for frame");
endmodule
`default_nettype wire

/* File: tpr_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tpr_sink_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic [47:0] dout_data,
  input  wire logic        dout_sop,
  input  wire logic        dout_eop,
  input  wire logic        dout_valid,
  output logic             dout_ready,
  output logic      [47:0] ctrl_body,
  output logic      [47:0] last_pix,
  output logic      [31:0] pix_count,
  output logic      [7:0]  frames
);
  logic [1:0] cyc;
  logic       in_img;

  // While stalling, the sink accepts a beat only one cycle in four, so the FIFO fills.
  assign dout_ready = !stall || (cyc == 2'h3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc       <= 2'h0;
      in_img    <= 1'b0;
      ctrl_body <= 48'h0;
      last_pix  <= 48'h0;
      pix_count <= 32'h0;
      frames    <= 8'h0;
    end else begin
      cyc <= cyc + 2'h1;
      if (dout_valid && dout_ready) begin
        if (dout_sop) begin
          in_img <= (dout_data[3:0] == tpr_pkg::PKT_IMAGE);
        end else if (!in_img) begin
          ctrl_body <= dout_data;
        end else begin
          pix_count <= pix_count + 32'h1;
          last_pix  <= dout_data;
          if (dout_eop) begin
            frames <= frames + 8'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tpr_run_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tpr_run_control_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [47:0] dout_data;
  logic        dout_sop;
  logic        dout_eop;
  logic        dout_valid;
  logic        dout_ready;
  logic        stall;
  logic [47:0] ctrl_body;
  logic [47:0] last_pix;
  logic [31:0] pix_count;
  logic [7:0]  frames;
  int          bad_count;
  int          compares;
  logic [31:0] rd;
  logic        er;
  logic        ce;
  logic        sel2;
  logic [31:0] prdata_b;
  logic        pready_b;
  logic        pslverr_b;
  logic [47:0] dout_data_b;
  logic        dout_sop_b;
  logic        dout_eop_b;
  logic        dout_valid_b;
  logic        dout_ready_b;
  logic [47:0] ctrl_body_b;
  logic [47:0] last_pix_b;
  logic [31:0] pix_count_b;
  logic [7:0]  frames_b;

  tpr_run_control u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel && !sel2), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dout_data(dout_data), .dout_sop(dout_sop), .dout_eop(dout_eop), .dout_valid(dout_valid),
    .dout_ready(dout_ready));

  tpr_sink_model u_sink (.pclk(pclk), .presetn(presetn), .stall(stall), .dout_data(dout_data),
    .dout_sop(dout_sop), .dout_eop(dout_eop), .dout_valid(dout_valid), .dout_ready(dout_ready),
    .ctrl_body(ctrl_body), .last_pix(last_pix), .pix_count(pix_count), .frames(frames));

  // A second block, interlaced and without colour registers, shares the bus behind its own select.
  tpr_run_control #(.UNIFORM_BG(1'b0), .INTERLACED(1'b1)) u_dut_alt (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel && sel2), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_b),
    .pready(pready_b), .pslverr(pslverr_b), .dout_data(dout_data_b), .dout_sop(dout_sop_b),
    .dout_eop(dout_eop_b), .dout_valid(dout_valid_b), .dout_ready(dout_ready_b));

  tpr_sink_model u_sink_alt (.pclk(pclk), .presetn(presetn), .stall(stall), .dout_data(dout_data_b),
    .dout_sop(dout_sop_b), .dout_eop(dout_eop_b), .dout_valid(dout_valid_b), .dout_ready(dout_ready_b),
    .ctrl_body(ctrl_body_b), .last_pix(last_pix_b), .pix_count(pix_count_b), .frames(frames_b));

  always #20 pclk = ~pclk;

  task automatic results();
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((sel2 ? pready_b : pready) !== 1'b1 && n < 100);
    if ((sel2 ? pready_b : pready) !== 1'b1) begin
      bad_count++;
    end
    rd = sel2 ? prdata_b : prdata;
    er = sel2 ? pslverr_b : pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rcheck(input logic [11:0] a, input logic [15:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    check("read data", {16'h0, rd}, {32'h0, exp});
    check("slave error", {47'h0, er}, {47'h0, experr});
  endtask

  task automatic wait_frames(input logic [7:0] n);
    int k;
    for (k = 0; k < 20000 && (sel2 ? frames_b : frames) !== n; k++) begin
      @(posedge pclk);
    end
    if ((sel2 ? frames_b : frames) !== n) begin
      bad_count++;
    end
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    results();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stall = 1'b1;
    ce = 1'b1;
    sel2 = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rcheck(12'h000, 16'h0000, 1'b0);
    rcheck(12'h004, 16'h0000, 1'b0);
    rcheck(12'h008, 16'h0020, 1'b0);
    rcheck(12'h00C, 16'h0020, 1'b0);
    rcheck(12'h010, 16'h0000, 1'b0);
    rcheck(12'h014, 16'h0000, 1'b0);
    rcheck(12'h018, 16'h0000, 1'b0);
    apb(1'b1, 12'h008, 32'hABCD0020);
    apb(1'b1, 12'h00C, 32'h00000021);
    apb(1'b1, 12'h010, 32'h5A5A1111);
    apb(1'b1, 12'h014, 32'h00002222);
    apb(1'b1, 12'h018, 32'h00003333);
    apb(1'b1, 12'h01C, 32'h00001234);
    check("unmapped write error", {47'h0, er}, 48'h1);
    apb(1'b1, 12'h004, 32'h00000000);
    rcheck(12'h008, 16'h0020, 1'b0);
    rcheck(12'h010, 16'h1111, 1'b0);
    rcheck(12'h01C, 16'h0000, 1'b1);
    ce <= 1'b0;
    apb(1'b1, 12'h00C, 32'h00000044);
    ce <= 1'b1;
    rcheck(12'h00C, 16'h0021, 1'b0);
    check("frames before run", {40'h0, frames}, 48'h0);
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    rcheck(12'h000, 16'h0001, 1'b0);
    rcheck(12'h004, 16'h0001, 1'b0);
    apb(1'b1, 12'h008, 32'h00000028);
    apb(1'b1, 12'h000, 32'h00000000);
    rcheck(12'h004, 16'h0001, 1'b0);
    wait_frames(8'h1);
    repeat (20) @(posedge pclk);
    rcheck(12'h004, 16'h0000, 1'b0);
    check("ctrl width", {32'h0, ctrl_body[15:0]}, 48'd32);
    check("ctrl rows", {32'h0, ctrl_body[31:16]}, 48'd33);
    check("ctrl format", {44'h0, ctrl_body[35:32]}, {44'h0, tpr_pkg::FMT_PROGRESSIVE});
    check("pixel count", {16'h0, pix_count}, 48'd1056);
    check("pixel colour", last_pix, 48'h333322221111);
    repeat (50) @(posedge pclk);
    check("frames after stop", {40'h0, frames}, 48'h1);
    stall <= 1'b0;
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000000);
    wait_frames(8'h2);
    check("second width", {32'h0, ctrl_body[15:0]}, 48'd40);
    check("second count", {16'h0, pix_count}, 48'd2376);
    sel2 <= 1'b1;
    rcheck(12'h010, 16'h0000, 1'b1);
    apb(1'b1, 12'h00C, 32'h00000021);
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b1, 12'h000, 32'h00000000);
    wait_frames(8'h2);
    check("field format", {44'h0, ctrl_body_b[35:32]}, {44'h0, tpr_pkg::FMT_FIELD_SECOND});
    check("field rows", {32'h0, ctrl_body_b[31:16]}, 48'd16);
    check("field pair count", {16'h0, pix_count_b}, 48'd1056);
    check("absent colour", last_pix_b, 48'h0);
    results();
  end
endmodule
`default_nettype wire
